//--- design/cer_in_stage.sv
`timescale 1ns/1ps
// Input register of one port; a falling-edge copy serves flow-through reads
module cer_in_stage
  import cer_pkg::*;
#(
  parameter int AW      = 7,
  parameter int DW      = 36,
  parameter int NB      = 4,
  parameter bit HAS_CLR = 1'b1
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          in_clr,
  input  wire logic          flow,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] data,
  input  wire logic [NB-1:0] be,
  cer_port_if.src            p
);
  typedef struct packed {
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [NB-1:0] be;
  } cer_req_t;

  cer_req_t r_q;
  cer_req_t r_d;
  cer_req_t n_q;
  logic     clr;

  // Blocks without an input clear tie it off
  assign clr = HAS_CLR & in_clr;

  always_comb begin
    r_d = r_q;
    if (ce) begin
      r_d = '{en: en, we: we, addr: addr, data: data, be: be};
    end
  end

  // Clear empties the stage at once; the array only sees it from the next edge
  always_ff @(posedge aclk or posedge clr) begin
    if (clr) begin
      r_q <= '0;
    end else if (!aresetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Falling-edge copy gives half a cycle of address setup to the array
  always_ff @(negedge aclk or posedge clr) begin
    if (clr) begin
      n_q <= '0;
    end else if (!aresetn) begin
      n_q <= '0;
    end else if (ce) begin
      n_q <= r_d;
    end
  end

  // Write fields always come from the rising-edge copy
  assign p.en   = flow ? n_q.en : r_q.en;
  assign p.addr = flow ? n_q.addr : r_q.addr;
  assign p.we   = r_q.we;
  assign p.data = r_q.data;
  assign p.be   = r_q.be;
endmodule

//--- design/cer_out_stage.sv
`timescale 1ns/1ps
// Optional read output register with its own asynchronous clear
module cer_out_stage
  import cer_pkg::*;
#(
  parameter int W       = 36,
  parameter bit PWR_CLR = 1'b1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         out_clr,
  input  wire logic         load,
  input  wire logic         bypass,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  always_comb begin
    q_d = q_q;
    if (ce && load) begin
      q_d = d;
    end
  end

  // Clear lands on the pins without waiting for an edge when bypass is low
  always_ff @(posedge aclk or posedge out_clr) begin
    if (out_clr) begin
      q_q <= '0;
    end else if (!aresetn && PWR_CLR) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  // Bypass saves a pipeline stage at the cost of array-to-pin timing
  assign q = bypass ? d : q_q;
endmodule

//--- design/cer_pkg.sv
package cer_pkg;
  // Block size variants, one-hot
  typedef enum logic [2:0] {
    CER_SMALL  = 3'h1,
    CER_MEDIUM = 3'h2,
    CER_LARGE  = 3'h4
  } cer_var_t;

  // Storage lane: one byte plus its parity bit
  localparam int CER_BYTE_W = 8;
  localparam int CER_LANE_W = 9;

  // Capacity in bits and widest word in lanes, per variant
  localparam int CER_SMALL_BITS   = 576;
  localparam int CER_MEDIUM_BITS  = 4608;
  localparam int CER_LARGE_BITS   = 589824;
  localparam int CER_SMALL_LANES  = 2;
  localparam int CER_MEDIUM_LANES = 4;
  localparam int CER_LARGE_LANES  = 16;

  // Operating modes held in the control register
  localparam int         CER_MODE_W    = 3;
  localparam logic [2:0] CER_MODE_TDP  = 3'h0;
  localparam logic [2:0] CER_MODE_SDP  = 3'h1;
  localparam logic [2:0] CER_MODE_SP   = 3'h2;
  localparam logic [2:0] CER_MODE_ROM  = 3'h3;
  localparam logic [2:0] CER_MODE_FIFO = 3'h4;
  localparam logic [2:0] CER_MODE_DSP  = 3'h5;

  // Register map
  localparam int          CER_AXI_AW   = 12;
  localparam logic [11:0] CER_CTRL_OFS = 12'h000;
  localparam logic [11:0] CER_STAT_OFS = 12'h004;

  // Control fields
  localparam int         CER_CTRL_W      = 7;
  localparam int         CER_CTRL_OREG_A = 3;
  localparam int         CER_CTRL_OREG_B = 4;
  localparam int         CER_CTRL_FLOW   = 5;
  localparam int         CER_CTRL_PGEN   = 6;
  localparam logic [6:0] CER_CTRL_RST    = 7'h19;

  // Status fields
  localparam int CER_STAT_EMPTY   = 0;
  localparam int CER_STAT_FULL    = 1;
  localparam int CER_STAT_COLL    = 2;
  localparam int CER_STAT_CNT_LSB = 8;

  localparam logic [1:0] CER_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CER_RESP_SLVERR = 2'h2;

  function automatic int cer_lanes(cer_var_t v);
    case (v)
      CER_SMALL: return CER_SMALL_LANES;
      CER_LARGE: return CER_LARGE_LANES;
      default:   return CER_MEDIUM_LANES;
    endcase
  endfunction

  function automatic int cer_depth(cer_var_t v);
    case (v)
      CER_SMALL: return CER_SMALL_BITS / (CER_SMALL_LANES * CER_LANE_W);
      CER_LARGE: return CER_LARGE_BITS / (CER_LARGE_LANES * CER_LANE_W);
      default:   return CER_MEDIUM_BITS / (CER_MEDIUM_LANES * CER_LANE_W);
    endcase
  endfunction
endpackage

//--- design/cer_port_if.sv
`timescale 1ns/1ps
// Registered request of one memory port
interface cer_port_if #(
  parameter int AW = 7,
  parameter int DW = 36,
  parameter int NB = 4
);
  logic          en;
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] data;
  logic [NB-1:0] be;
  modport src (output en, we, addr, data, be);
  modport dst (input en, we, addr, data, be);
endinterface

//--- design/cer_ram_top.sv
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - True dual-port only on medium and large
// - Simple dual-port: read and write together, old data
// - Single-port: written data shown, registered one edge later
// - Ports may have different data widths
// - All inputs registered; write strobe made internally
// - Read output register may be bypassed
// - Flow-through reads on small and medium simple dual-port
// - Medium block holds two half-size single-port memories
// - Input clear acts now, seen at next edge
// - Output clear changes registered output immediately, not a bypassed one
// - Large has no preload; ROM by write-then-lock
// - Large clears only output registers
// - Small shapes up to 32 by 18
// - Medium shapes up to 128 by 36
// - Large shapes up to 4K by 144
// - Parity optional; RAM, ROM or FIFO use
// - Byte enables mask lanes; one parity bit per byte
// - Small write side shares one clock
module cer_ram_top
  import cer_pkg::*;
#(
  parameter cer_var_t VARIANT = CER_MEDIUM,
  parameter int       LANES   = cer_lanes(VARIANT),
  parameter int       DEPTH   = cer_depth(VARIANT)
) (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic                                 ce,
  input  wire logic                                 in_clr,
  input  wire logic                                 out_clr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [CER_AXI_AW-1:0]                s_axi_awaddr,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  output logic [1:0]                                s_axi_bresp,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  input  wire logic [CER_AXI_AW-1:0]                s_axi_araddr,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  input  wire logic                                 a_en,
  input  wire logic                                 a_we,
  input  wire logic [$clog2(DEPTH*LANES)-1:0]       a_addr,
  input  wire logic [CER_LANE_W-1:0]                a_wdata,
  output logic      [CER_LANE_W-1:0]                a_q,
  input  wire logic                                 b_en,
  input  wire logic                                 b_we,
  input  wire logic [$clog2(DEPTH)-1:0]             b_addr,
  input  wire logic [LANES*CER_LANE_W-1:0]          b_wdata,
  input  wire logic [LANES-1:0]                     b_be,
  output logic      [LANES*CER_LANE_W-1:0]          b_q
);
  localparam int W   = LANES * CER_LANE_W;
  localparam int LB  = $clog2(LANES);
  localparam int AWB = $clog2(DEPTH);
  localparam int AWA = AWB + LB;

  typedef logic [LANES-1:0][CER_LANE_W-1:0] cer_word_t;

  typedef struct packed {
    cer_word_t [DEPTH-1:0] mem;
    logic [AWB:0]          cnt;
    logic [AWB-1:0]        wp;
    logic [AWB-1:0]        rp;
    logic                  coll;
    logic [CER_CTRL_W-1:0] ctrl;
    logic                  awrdy;
    logic                  wrdy;
    logic                  arrdy;
    logic                  aw_ok;
    logic                  w_ok;
    logic [CER_AXI_AW-1:0] awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } cer_state_t;

  cer_state_t     s_q;
  cer_state_t     s_d;
  logic [2:0]     mode;
  logic           flow;
  logic           is_dsp;
  logic [AWB-1:0] a_wi;
  logic [AWB-1:0] b_wi;
  logic [LB-1:0]  a_lane;
  cer_word_t      b_lanes;
  logic           a_wr;
  logic           a_rd;
  logic           b_wr;
  logic           b_rd;
  logic           push;
  logic           pop;
  logic           full;
  logic           empty;
  logic [W-1:0]   b_d;
  logic [CER_LANE_W-1:0] a_d;
  logic [LANES-1:0]      b_be_in;

  cer_port_if #(.AW(AWA), .DW(CER_LANE_W), .NB(1)) pa ();
  cer_port_if #(.AW(AWB), .DW(W), .NB(LANES))      pb ();

  // Optionally replace the stored ninth bit with even parity of the byte
  function automatic logic [CER_LANE_W-1:0] par_lane(logic [CER_LANE_W-1:0] l, logic gen);
    par_lane = l;
    if (gen) begin
      par_lane[CER_BYTE_W] = ^l[CER_BYTE_W-1:0];
    end
  endfunction

  // Word-aligned register decode
  function automatic logic is_reg(logic [CER_AXI_AW-1:0] a, logic [CER_AXI_AW-1:0] ofs);
    is_reg = (a[CER_AXI_AW-1:2] == ofs[CER_AXI_AW-1:2]);
  endfunction

  // Small blocks have no byte enables, every lane writes
  assign b_be_in = (VARIANT == CER_SMALL) ? '1 : b_be;

  // Both ports share aclk, so the small block's write side is on one clock
  cer_in_stage #(.AW(AWA), .DW(CER_LANE_W), .NB(1), .HAS_CLR(VARIANT != CER_LARGE)) u_in_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .in_clr  (in_clr),
    .flow    (1'b0),
    .en      (a_en),
    .we      (a_we),
    .addr    (a_addr),
    .data    (a_wdata),
    .be      (1'b1),
    .p       (pa)
  );

  cer_in_stage #(.AW(AWB), .DW(W), .NB(LANES), .HAS_CLR(VARIANT != CER_LARGE)) u_in_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .in_clr  (in_clr),
    .flow    (flow),
    .en      (b_en),
    .we      (b_we),
    .addr    (b_addr),
    .data    (b_wdata),
    .be      (b_be_in),
    .p       (pb)
  );

  // Effective mode: unsupported choices fall back to the nearest one
  always_comb begin
    mode = s_q.ctrl[CER_MODE_W-1:0];
    if (mode == CER_MODE_TDP && VARIANT == CER_SMALL) begin
      mode = CER_MODE_SDP;
    end
    if (mode == CER_MODE_DSP && VARIANT != CER_MEDIUM) begin
      mode = CER_MODE_SP;
    end
  end

  // Flow-through only where the array timing allows it
  assign flow = s_q.ctrl[CER_CTRL_FLOW] && mode == CER_MODE_SDP
                && VARIANT != CER_LARGE;
  assign is_dsp = (mode == CER_MODE_DSP);

  // Narrow port A addresses one lane; wide port B a whole word
  assign a_lane  = pa.addr[LB-1:0];
  assign b_lanes = pb.data;
  assign a_wi    = is_dsp ? {1'b0, pa.addr[AWA-2:LB]} : pa.addr[AWA-1:LB];
  assign b_wi    = is_dsp ? {1'b1, pb.addr[AWB-2:0]} : pb.addr;

  // Port strobes per mode; ROM mode blocks every write
  assign a_wr = pa.en && pa.we && (mode == CER_MODE_TDP || mode == CER_MODE_SDP
                || mode == CER_MODE_SP || is_dsp);
  assign a_rd = pa.en && !pa.we && (mode == CER_MODE_TDP || mode == CER_MODE_SP || is_dsp);
  assign b_wr = pb.en && pb.we && (mode == CER_MODE_TDP || is_dsp);
  assign b_rd = pb.en && !pb.we && (mode == CER_MODE_TDP || mode == CER_MODE_SDP
                || mode == CER_MODE_ROM || is_dsp);
  assign full  = (s_q.cnt == (AWB+1)'(DEPTH));
  assign empty = (s_q.cnt == '0);
  assign push  = mode == CER_MODE_FIFO && pb.en && pb.we && !full;
  assign pop   = mode == CER_MODE_FIFO && pb.en && !pb.we && !empty;

  // Reads see the array before this cycle's write: old data on collision
  assign a_d = (mode == CER_MODE_SP && a_wr) ? par_lane(pa.data, s_q.ctrl[CER_CTRL_PGEN])
               : s_q.mem[a_wi][a_lane];
  assign b_d = (mode == CER_MODE_FIFO) ? s_q.mem[s_q.rp] : s_q.mem[b_wi];

  cer_out_stage #(.W(CER_LANE_W), .PWR_CLR(VARIANT != CER_LARGE)) u_out_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .out_clr (out_clr),
    .load    (a_rd || (a_wr && mode == CER_MODE_SP)),
    .bypass  (!s_q.ctrl[CER_CTRL_OREG_A]),
    .d       (a_d),
    .q       (a_q)
  );

  cer_out_stage #(.W(W), .PWR_CLR(VARIANT != CER_LARGE)) u_out_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .out_clr (out_clr),
    .load    (b_rd || pop),
    .bypass  (!s_q.ctrl[CER_CTRL_OREG_B] || flow),
    .d       (b_d),
    .q       (b_q)
  );

  // Next state: array, FIFO pointers, register slave
  always_comb begin
    s_d = s_q;
    // Self-timed write: the strobe is the registered enable on this edge
    if (a_wr) begin
      s_d.mem[a_wi][a_lane] = par_lane(pa.data, s_q.ctrl[CER_CTRL_PGEN]);
    end
    for (int l = 0; l < LANES; l++) begin
      if ((b_wr || push) && pb.be[l]) begin
        s_d.mem[push ? s_q.wp : b_wi][l] = par_lane(b_lanes[l], s_q.ctrl[CER_CTRL_PGEN]);
      end
    end
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AWB+1)'(push) - (AWB+1)'(pop);
    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_q.awrdy) begin
      s_d.aw_ok  = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wrdy) begin
      s_d.w_ok  = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_ok && s_q.w_ok) begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = CER_RESP_OKAY;
      if (is_reg(s_q.awaddr, CER_CTRL_OFS)) begin
        if (s_q.wstrb[0]) begin
          s_d.ctrl = s_q.wdata[CER_CTRL_W-1:0];
        end
      end else if (is_reg(s_q.awaddr, CER_STAT_OFS)) begin
        if (s_q.wstrb[0] && s_q.wdata[CER_STAT_COLL]) begin
          s_d.coll = 1'b0;
        end
      end else begin
        s_d.bresp = CER_RESP_SLVERR;
      end
    end
    // Same-word read during write: flag it; set wins over a clear
    if ((a_wr && b_rd && a_wi == b_wi) || (b_wr && a_rd && a_wi == b_wi)) begin
      s_d.coll = 1'b1;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arrdy) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = CER_RESP_OKAY;
      s_d.rdata  = '0;
      if (is_reg(s_axi_araddr, CER_CTRL_OFS)) begin
        s_d.rdata = 32'(s_q.ctrl);
      end else if (is_reg(s_axi_araddr, CER_STAT_OFS)) begin
        s_d.rdata = 32'(s_q.cnt) << CER_STAT_CNT_LSB;
        s_d.rdata[CER_STAT_EMPTY] = empty;
        s_d.rdata[CER_STAT_FULL]  = full;
        s_d.rdata[CER_STAT_COLL]  = s_q.coll;
      end else begin
        s_d.rresp = CER_RESP_SLVERR;
      end
    end
    // Ready flags are registered so the bus outputs come from flops
    s_d.awrdy = !s_d.aw_ok && !s_d.bvalid;
    s_d.wrdy  = !s_d.w_ok && !s_d.bvalid;
    s_d.arrdy = !s_d.rvalid;
  end

  // Array contents are not reset; no preload is offered on any variant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.cnt    <= '0;
      s_q.wp     <= '0;
      s_q.rp     <= '0;
      s_q.coll   <= 1'b0;
      s_q.ctrl   <= CER_CTRL_RST;
      s_q.awrdy  <= 1'b1;
      s_q.wrdy   <= 1'b1;
      s_q.arrdy  <= 1'b1;
      s_q.aw_ok  <= 1'b0;
      s_q.w_ok   <= 1'b0;
      s_q.awaddr <= '0;
      s_q.wdata  <= '0;
      s_q.wstrb  <= '0;
      s_q.bvalid <= 1'b0;
      s_q.bresp  <= CER_RESP_OKAY;
      s_q.rvalid <= 1'b0;
      s_q.rdata  <= '0;
      s_q.rresp  <= CER_RESP_OKAY;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awrdy;
  assign s_axi_wready  = s_q.wrdy;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arrdy;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  // Checks on the memory behaviour
  small_no_tdp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (VARIANT == CER_SMALL && pb.en && pb.we) |-> !b_wr) else $error("small port b wrote");
  rom_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && mode == CER_MODE_ROM) |=> $stable(s_q.mem)) else $error("rom contents changed");
  sp_thru_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == CER_MODE_SP && a_wr && !s_q.ctrl[CER_CTRL_OREG_A] && !out_clr)
    |-> a_q == par_lane(pa.data, s_q.ctrl[CER_CTRL_PGEN])) else $error("sp write not shown");
  sp_reg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && mode == CER_MODE_SP && a_wr && s_q.ctrl[CER_CTRL_OREG_A] && !out_clr)
    |=> (out_clr || a_q == $past(a_d))) else $error("sp write late");
  out_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (out_clr && s_q.ctrl[CER_CTRL_OREG_B] && !flow) |-> b_q == '0) else $error("out clear");
  in_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (VARIANT != CER_LARGE && in_clr) |-> (!pa.we && !pb.we)) else $error("in clear");
  coll_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && a_wr && b_rd && a_wi == b_wi) |=> s_q.coll) else $error("collision missed");
  fifo_cnt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && push && !pop) |=> s_q.cnt == $past(s_q.cnt) + 1'b1) else $error("fifo count");
endmodule

//--- tb/cer_fabric_b.sv
`timescale 1ns/1ps
// Fabric logic on port B; idle address and data lines show the inverse of their last value
module cer_fabric_b
  import cer_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [6:0]  addr,
  input  wire logic [35:0] wdata,
  input  wire logic [3:0]  be,
  output logic             b_en,
  output logic             b_we,
  output logic [6:0]       b_addr,
  output logic [35:0]      b_wdata,
  output logic [3:0]       b_be
);
  logic [6:0]  addr_q;
  logic [35:0] data_q;
  // Keep last values so released lines move away from them
  always_ff @(posedge aclk) begin
    if (req) begin
      addr_q <= addr;
      data_q <= wdata;
    end
  end
  // Write enable held low outside an asked-for write
  always_comb begin
    b_en    = req;
    b_we    = req & wr;
    b_addr  = req ? addr : ~addr_q;
    b_wdata = req ? wdata : ~data_q;
    b_be    = req ? be : 4'h0;
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb
  import cer_pkg::*;
;
  logic aclk, aresetn, ce, in_clr, out_clr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, b_be, b_bm;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        a_en, a_we, b_en, b_we, b_req, b_wr;
  logic [8:0]  a_addr, a_wdata, a_q;
  logic [6:0]  b_addr, b_ad;
  logic [35:0] b_wdata, b_wd, b_q, exp_w;
  int          n_fail, compares;
  cer_ram_top cer_ram_top_i (.aclk, .aresetn, .ce, .in_clr, .out_clr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .a_en, .a_we, .a_addr, .a_wdata,
    .a_q, .b_en, .b_we, .b_addr, .b_wdata, .b_be, .b_q);
  cer_fabric_b cer_fabric_b_i (.aclk, .req(b_req), .wr(b_wr), .addr(b_ad), .wdata(b_wd),
    .be(b_bm), .b_en, .b_we, .b_addr, .b_wdata, .b_be);
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    compares++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // Bus waits are bounded; running out ends the run as a failure
  task automatic axi_wr(input logic [11:0] ad, input logic [31:0] v, output logic [1:0] rs);
    int i;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1; s_axi_awaddr <= ad; s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v; s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    if (i == 50) begin n_fail++; tally_and_finish(); end
  endtask
  task automatic axi_rd(input logic [11:0] ad, output logic [31:0] v, output logic [1:0] rs);
    int i;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1; s_axi_araddr <= ad; s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    rs = s_axi_rresp;
    if (i == 50) begin n_fail++; tally_and_finish(); end
  endtask
  task automatic ctrl_set(input logic [31:0] v);
    axi_wr(CER_CTRL_OFS, v, r);
    check(r, CER_RESP_OKAY);
  endtask
  // One cycle of request on a port; returns at the capture edge
  task automatic a_op(input logic we, input logic [8:0] ad, input logic [8:0] v);
    @(posedge aclk);
    a_en <= 1'b1; a_we <= we; a_addr <= ad; a_wdata <= v;
    @(posedge aclk);
    a_en <= 1'b0; a_we <= 1'b0;
  endtask
  task automatic b_op(input logic we, input logic [6:0] ad, input logic [35:0] v,
                      input logic [3:0] m);
    @(posedge aclk);
    b_req <= 1'b1; b_wr <= we; b_ad <= ad; b_wd <= v; b_bm <= m;
    @(posedge aclk);
    b_req <= 1'b0;
  endtask
  task automatic t_reset();
    check(a_q, 9'h0);
    check(b_q, 36'h0);
    axi_rd(CER_CTRL_OFS, d, r);
    check(d, CER_CTRL_RST);
    axi_rd(CER_STAT_OFS, d, r);
    check(d, 32'h1);
    axi_rd(12'h100, d, r);
    check({d, r}, {32'h0, CER_RESP_SLVERR});
    axi_wr(12'h100, 32'h7F, r);
    check(r, CER_RESP_SLVERR);
    $display("t_reset done");
  endtask
  // Narrow writes on A, wide reads on B, then a same-word collision and clears
  task automatic t_sdp();
    @(posedge aclk);
    for (int l = 0; l < 4; l++) begin
      a_en <= 1'b1; a_we <= 1'b1; a_addr <= {7'h05, 2'(l)}; a_wdata <= 9'(9'h1A0 + l);
      exp_w[l*9 +: 9] = 9'(9'h1A0 + l);
      @(posedge aclk);
    end
    a_en <= 1'b0; a_we <= 1'b0;
    b_op(1'b0, 7'h05, 36'h0, 4'h0);
    @(posedge aclk); #1;
    check(b_q, exp_w);
    @(posedge aclk);
    a_en <= 1'b1; a_we <= 1'b1; a_addr <= {7'h05, 2'h0}; a_wdata <= 9'h055;
    b_req <= 1'b1; b_wr <= 1'b0; b_ad <= 7'h05;
    @(posedge aclk);
    a_en <= 1'b0; a_we <= 1'b0; b_req <= 1'b0;
    @(posedge aclk); #1;
    check(b_q, exp_w);
    exp_w[8:0] = 9'h055;
    @(posedge aclk);
    out_clr <= 1'b1;
    #1 check(b_q, 36'h0);
    @(posedge aclk);
    out_clr <= 1'b0;
    b_op(1'b0, 7'h05, 36'h0, 4'h0);
    in_clr <= 1'b1;
    @(posedge aclk); #1;
    check(b_q, 36'h0);
    @(posedge aclk);
    in_clr <= 1'b0;
    axi_rd(CER_STAT_OFS, d, r);
    check(d[CER_STAT_COLL], 1'b1);
    axi_wr(CER_STAT_OFS, 32'h4, r);
    axi_rd(CER_STAT_OFS, d, r);
    check(d, 32'h1);
    $display("t_sdp done");
  endtask
  task automatic t_bypass();
    ctrl_set(32'h09);
    b_op(1'b0, 7'h05, 36'h0, 4'h0);
    #1 check(b_q, exp_w);
    a_op(1'b1, {7'h06, 2'h0}, 9'h0C3);
    ctrl_set(32'h29);
    @(posedge aclk);
    b_req <= 1'b1; b_wr <= 1'b0; b_ad <= 7'h06;
    @(negedge aclk); #1;
    check(b_q[8:0], 9'h0C3);
    @(posedge aclk);
    b_req <= 1'b0;
    $display("t_bypass done");
  endtask
  task automatic t_sp_be_rom();
    ctrl_set(32'h0A);
    a_op(1'b1, 9'h1F3, 9'h13C);
    @(posedge aclk); #1;
    check(a_q, 9'h13C);
    ctrl_set(32'h02);
    a_op(1'b1, 9'h1F2, 9'h0A5);
    #1 check(a_q, 9'h0A5);
    ctrl_set(32'h18);
    b_op(1'b1, 7'h07, 36'hAAAAAAAAA, 4'hF);
    b_op(1'b1, 7'h07, 36'h555555555, 4'h5);
    exp_w = (36'h555555555 & 36'h007FC01FF) | (36'hAAAAAAAAA & ~36'h007FC01FF);
    b_op(1'b0, 7'h07, 36'h0, 4'h0);
    @(posedge aclk); #1;
    check(b_q, exp_w);
    ctrl_set(32'h1B);
    b_op(1'b1, 7'h07, 36'h0, 4'hF);
    b_op(1'b0, 7'h07, 36'h0, 4'h0);
    @(posedge aclk); #1;
    check(b_q, exp_w);
    $display("t_sp_be_rom done");
  endtask
  // Two half-size memories: a word write on B must not reach A's half
  task automatic t_dual();
    ctrl_set(32'h1D);
    a_op(1'b1, {7'h03, 2'h0}, 9'h11A);
    b_op(1'b1, 7'h03, 36'hFFFFFFFFF, 4'hF);
    a_op(1'b0, {7'h03, 2'h0}, 9'h000);
    @(posedge aclk); #1;
    check(a_q, 9'h11A);
    b_op(1'b0, 7'h03, 36'h0, 4'h0);
    @(posedge aclk); #1;
    check(b_q, 36'hFFFFFFFFF);
    $display("t_dual done");
  endtask
  // FIFO on port B with generated parity; pops come back in push order
  task automatic t_fifo();
    ctrl_set(32'h54);
    b_op(1'b1, 7'h00, 36'h0000000FF, 4'hF);
    b_op(1'b1, 7'h00, 36'h000000001, 4'hF);
    axi_rd(CER_STAT_OFS, d, r);
    check(d, 32'h200);
    b_op(1'b0, 7'h00, 36'h0, 4'h0);
    @(posedge aclk); #1;
    check(b_q, 36'h0000000FF);
    b_op(1'b0, 7'h00, 36'h0, 4'h0);
    @(posedge aclk); #1;
    check(b_q, 36'h000000101);
    $display("t_fifo done");
  endtask
  initial begin
    {aresetn, in_clr, out_clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, a_en, a_we, b_req, b_wr} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, a_addr, a_wdata} = '0;
    {b_ad, b_wd, b_bm, exp_w} = '0;
    s_axi_wstrb = 4'hF;
    ce = 1'b1;
    n_fail = 0;
    compares = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk); #1;
    t_reset();
    t_sdp();
    t_bypass();
    t_sp_be_rom();
    t_dual();
    t_fifo();
    tally_and_finish();
  end
endmodule
